// File: src/ulbn_top.v
/*
  extended status and control of an asynchronous serial port: lin break
  detection, receive edge, polarity inversion, break generation, ninth bits,
  single-wire direction, plus a small receiver and transmitter to drive them.
  assumes an avalon-mm master on mclk and a 16x oversampling baud tick.
*/
// Local design decisions: the Avalon-MM slave port and the register offsets.
// Behaviour
// (RQ1) lin break with detection enabled sets lin_break_flag; write one clears
// (RQ2) active rx edge, by polarity, sets rx_edge_flag; write one clears
// (RQ3) rx_polarity_invert inverts the receive pin for every purpose
// (RQ4) in standby, idle sets line_quiet_flag only if wake_idle_sets_flag
// (RQ5) sent break is 10/11 or 13/14 bit times by long_break_select
// (RQ6) framing error detection ignores long_break_select
// (RQ7) break threshold 10/11 bits, or 11/12 with lin detection enabled
// (RQ8) lin detection enabled blocks framing_error_flag and rx_full_flag
// (RQ9) receiver_active_flag set at valid start, cleared on idle line
// (RQ10) software with internal oscillator on lin should enable lin detection
// (RQ11) ninth received bit shown above the received byte
// (RQ12) software reads ninth_rx_bit before the data register
// (RQ13) data write sends nine bits with ninth_tx_bit on top; bit is kept
// (RQ14) software updates ninth_tx_bit before the data write when needed
// (RQ15) single-wire mode: single_wire_tx_direction sets transmit pin direction
// (RQ16) line high a full character after activity sets line_quiet_flag
// (RQ17) stop bit sampled zero sets framing_error_flag with rx_full_flag
// (RQ18) writing zero to flags or to receiver_active_flag changes nothing
`include "ulbn_defs.vh"
`default_nettype none
module ulbn_top (
  input wire mclk,
  input wire rst_n,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire baud_tick,
  input wire receive_pin,
  input wire transmit_pin_in,
  output reg transmit_pin_out,
  output reg transmit_pin_oe_n,
  output reg irq
);
  localparam RX_IDLE = 2'h0;
  localparam RX_DATA = 2'h1;
  localparam RX_STOP = 2'h2;
  localparam TX_IDLE = 2'h0;
  localparam TX_SHIFT = 2'h1;
  localparam TX_BREAK = 2'h2;

  reg [7:0] ctl_q;
  reg lbk_flag_q, edge_flag_q, rx_inv_q, wake_idle_q, long_brk_q, lbk_en_q, rx_act_q;
  reg ninth_rx_q, ninth_tx_q, sw_dir_q;
  reg [7:0] rx_byte_q;
  reg [5:0] irq_st_q, irq_mask_q;
  reg ack_q;
  reg line_q, line_prev_q;
  reg [1:0] rx_state_q, tx_state_q;
  reg [3:0] rx_sub_q, tx_sub_q;
  reg [3:0] rx_cnt_q, tx_cnt_q;
  reg [8:0] rx_sh_q;
  reg [10:0] tx_sh_q;
  reg [4:0] brk_left_q;
  reg quiet_armed_q;
  wire nine = ctl_q[`ULBN_BIT_NINE];
  wire single_wire = ctl_q[`ULBN_BIT_LOOP] & ctl_q[`ULBN_BIT_LOOP_SRC];
  // a write lands at the edge where the master sees waitrequest low
  wire wr = avs_write & ack_q;
  wire rd = avs_read & ~ack_q;
  wire [7:0] wb = avs_writedata[7:0];
  ////////////////////////////////////////////////////////////////////////////
  // receive line: loop source in single-wire mode, then optional inversion
  wire raw_in = single_wire ? transmit_pin_in : receive_pin;
  wire line_d = raw_in ^ rx_inv_q; // see (RQ3)
  always @(posedge mclk) begin
    if (!rst_n) begin
      line_q <= 1'b1;
      line_prev_q <= 1'b1;
    end else begin
      line_q <= line_d;
      line_prev_q <= line_q;
    end
  end
  // after inversion the active edge is always a fall of line_q
  wire edge_ev = line_prev_q & ~line_q; // see (RQ2)
  ////////////////////////////////////////////////////////////////////////////
  // break and idle counters; threshold does not depend on long_break_select
  wire [4:0] brk_lim = (lbk_en_q ? `ULBN_BRK_RX_LONG : `ULBN_BRK_RX_SHORT)
    + {4'h0, nine}; // see (RQ7) (RQ6)
  wire [4:0] quiet_lim = `ULBN_IDLE_CHAR + {4'h0, nine};
  wire brk_hit, quiet_hit;
  reg brk_hit_prev_q, quiet_prev_q;
  ulbn_bitcnt u_brk (
    .mclk(mclk), .rst_n(rst_n), .tick(baud_tick), .run(~line_q),
    .limit(brk_lim), .hit(brk_hit)
  );
  ulbn_bitcnt u_quiet (
    .mclk(mclk), .rst_n(rst_n), .tick(baud_tick), .run(line_q),
    .limit(quiet_lim), .hit(quiet_hit)
  );
  wire brk_ev = brk_hit & ~brk_hit_prev_q;
  wire quiet_ev = quiet_hit & ~quiet_prev_q & quiet_armed_q; // see (RQ16)
  wire quiet_sets = quiet_ev & (~ctl_q[`ULBN_BIT_STANDBY] | wake_idle_q); // see (RQ4)
  ////////////////////////////////////////////////////////////////////////////
  // receiver: midpoint sampling at 16x, 8 or 9 data bits
  wire mid = baud_tick & (rx_sub_q == 4'h7);
  wire [3:0] rx_bits = nine ? 4'h9 : 4'h8;
  reg char_ev, ferr_ev;
  always @* begin
    char_ev = 1'b0;
    ferr_ev = 1'b0;
    if (rx_state_q == RX_STOP && mid && !lbk_en_q) begin // see (RQ8)
      char_ev = 1'b1;
      ferr_ev = ~line_q; // see (RQ17)
    end
  end
  always @(posedge mclk) begin
    if (!rst_n) begin
      rx_state_q <= RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_act_q <= 1'b0;
      brk_hit_prev_q <= 1'b0;
      quiet_prev_q <= 1'b0;
      quiet_armed_q <= 1'b0;
    end else begin
      brk_hit_prev_q <= brk_hit;
      quiet_prev_q <= quiet_hit;
      if (baud_tick) begin
        rx_sub_q <= rx_sub_q + 4'h1;
      end
      if (rx_state_q == RX_IDLE && edge_ev) begin
        rx_sub_q <= 4'h0;
      end
      if (quiet_ev) begin
        quiet_armed_q <= 1'b0;
      end else if (!line_q) begin
        quiet_armed_q <= 1'b1;
      end
      if (quiet_hit) begin
        rx_act_q <= 1'b0; // see (RQ9)
      end
      case (rx_state_q)
        RX_IDLE: begin
          if (mid && !line_q) begin
            rx_act_q <= 1'b1; // see (RQ9)
            rx_cnt_q <= 4'h0;
            rx_state_q <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (mid) begin
            rx_sh_q <= nine ? {line_q, rx_sh_q[8:1]} : {1'b0, line_q, rx_sh_q[7:1]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q + 4'h1 == rx_bits) begin
              rx_state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (mid) begin
            rx_state_q <= RX_IDLE;
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // transmitter: data frame or break, one bit per 16 ticks
  wire send_data = wr && avs_address == `ULBN_OFS_DATA;
  wire send_brk = wr && avs_address == `ULBN_OFS_CTL && wb[`ULBN_BIT_SEND_BRK];
  wire [4:0] brk_len = (long_brk_q ? `ULBN_BRK_TX_LONG : `ULBN_BRK_TX_SHORT)
    + {4'h0, nine}; // see (RQ5)
  wire [3:0] frame_len = nine ? 4'hb : 4'ha;
  wire bit_end = baud_tick & (tx_sub_q == 4'hf);
  reg tx_done_ev;
  always @(posedge mclk) begin
    if (!rst_n) begin
      tx_state_q <= TX_IDLE;
      tx_sub_q <= 4'h0;
      tx_cnt_q <= 4'h0;
      tx_sh_q <= 11'h7ff;
      brk_left_q <= 5'h00;
      tx_done_ev <= 1'b0;
      transmit_pin_out <= 1'b1;
      transmit_pin_oe_n <= 1'b0;
    end else begin
      tx_done_ev <= 1'b0;
      // pin released only when single-wire mode asks for input
      transmit_pin_oe_n <= single_wire & ~sw_dir_q; // see (RQ15)
      if (baud_tick) begin
        tx_sub_q <= tx_sub_q + 4'h1;
      end
      case (tx_state_q)
        TX_IDLE: begin
          transmit_pin_out <= 1'b1;
          tx_sub_q <= 4'h0;
          if (send_brk) begin
            brk_left_q <= brk_len;
            tx_state_q <= TX_BREAK;
          end else if (send_data) begin
            // frame lsb first: start, data, ninth bit when enabled, stop
            tx_sh_q <= nine ? {1'b1, ninth_tx_q, wb, 1'b0}
              : {1'b1, 1'b1, wb, 1'b0}; // see (RQ13)
            tx_cnt_q <= 4'h0;
            tx_state_q <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          transmit_pin_out <= tx_sh_q[0];
          if (bit_end) begin
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q + 4'h1 == frame_len) begin
              tx_state_q <= TX_IDLE;
              tx_done_ev <= 1'b1;
            end
          end
        end
        TX_BREAK: begin
          transmit_pin_out <= 1'b0;
          if (bit_end) begin
            brk_left_q <= brk_left_q - 5'h01;
            if (brk_left_q == 5'h01) begin
              tx_state_q <= TX_IDLE;
              tx_done_ev <= 1'b1;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // registers; set wins over write-one clear on every sticky flag
  wire [7:0] ext_status = {lbk_flag_q, edge_flag_q, 1'b0, rx_inv_q, wake_idle_q,
    long_brk_q, lbk_en_q, rx_act_q};
  wire [7:0] extra_ctl = {ninth_rx_q, ninth_tx_q, sw_dir_q, 5'h00};
  wire [5:0] ev_vec = {tx_done_ev, ferr_ev, char_ev, quiet_sets, edge_ev, brk_ev & lbk_en_q};
  wire st_wr = wr && avs_address == `ULBN_OFS_EXT_STATUS;
  always @(posedge mclk) begin
    if (!rst_n) begin
      ctl_q <= `ULBN_RST_BYTE;
      {lbk_flag_q, edge_flag_q, rx_inv_q, wake_idle_q, long_brk_q, lbk_en_q} <= 6'h00;
      {ninth_rx_q, ninth_tx_q, sw_dir_q} <= 3'h0;
      rx_byte_q <= `ULBN_RST_BYTE;
      irq_st_q <= 6'h00;
      irq_mask_q <= 6'h00;
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
      irq <= |(irq_st_q & irq_mask_q);
      // writing one clears, zero leaves the flag; event wins
      lbk_flag_q <= (brk_ev & lbk_en_q)
        | (lbk_flag_q & ~(st_wr & wb[`ULBN_BIT_LBK_FLAG])); // see (RQ1) (RQ18)
      edge_flag_q <= edge_ev
        | (edge_flag_q & ~(st_wr & wb[`ULBN_BIT_EDGE_FLAG])); // see (RQ2) (RQ18)
      irq_st_q <= ev_vec | (irq_st_q
        & ~((wr && avs_address == `ULBN_OFS_IRQ_STATUS) ? wb[5:0] : 6'h00));
      if (st_wr) begin
        // receiver_active_flag is not writable
        rx_inv_q <= wb[`ULBN_BIT_RX_INV];
        wake_idle_q <= wb[`ULBN_BIT_WAKE_IDLE];
        long_brk_q <= wb[`ULBN_BIT_LONG_BRK];
        lbk_en_q <= wb[`ULBN_BIT_LBK_EN]; // see (RQ18)
      end
      if (wr && avs_address == `ULBN_OFS_EXTRA_CTL) begin
        ninth_tx_q <= wb[`ULBN_BIT_NINTH_TX];
        sw_dir_q <= wb[`ULBN_BIT_SW_DIR];
      end
      if (wr && avs_address == `ULBN_OFS_CTL) begin
        ctl_q <= {4'h0, wb[3:0]};
      end
      if (wr && avs_address == `ULBN_OFS_IRQ_MASK) begin
        irq_mask_q <= wb[5:0];
      end
      if (char_ev) begin
        rx_byte_q <= rx_sh_q[7:0];
        ninth_rx_q <= nine & rx_sh_q[8]; // see (RQ11)
      end
      if (rd) begin
        case (avs_address)
          `ULBN_OFS_EXT_STATUS: avs_readdata <= {24'h000000, ext_status};
          `ULBN_OFS_EXTRA_CTL: avs_readdata <= {24'h000000, extra_ctl};
          `ULBN_OFS_CTL: avs_readdata <= {24'h000000, ctl_q};
          `ULBN_OFS_DATA: avs_readdata <= {24'h000000, rx_byte_q};
          `ULBN_OFS_IRQ_STATUS: avs_readdata <= {26'h0000000, irq_st_q};
          `ULBN_OFS_IRQ_MASK: avs_readdata <= {26'h0000000, irq_mask_q};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: inc/ulbn_defs.vh
/*
  register map, field positions, reset values and timing counts of the
  extended serial status/control block.
  assumes a 50 mhz bus clock and a baud tick from outside.
*/
`ifndef ULBN_DEFS_VH
`define ULBN_DEFS_VH
`define ULBN_OFS_EXT_STATUS 3'h0
`define ULBN_OFS_EXTRA_CTL 3'h1
`define ULBN_OFS_CTL 3'h2
`define ULBN_OFS_DATA 3'h3
`define ULBN_OFS_IRQ_STATUS 3'h4
`define ULBN_OFS_IRQ_MASK 3'h5
`define ULBN_BIT_LBK_FLAG 7
`define ULBN_BIT_EDGE_FLAG 6
`define ULBN_BIT_RX_INV 4
`define ULBN_BIT_WAKE_IDLE 3
`define ULBN_BIT_LONG_BRK 2
`define ULBN_BIT_LBK_EN 1
`define ULBN_BIT_RX_ACTIVE 0
`define ULBN_BIT_NINTH_RX 7
`define ULBN_BIT_NINTH_TX 6
`define ULBN_BIT_SW_DIR 5
`define ULBN_BIT_NINE 0
`define ULBN_BIT_STANDBY 1
`define ULBN_BIT_LOOP 2
`define ULBN_BIT_LOOP_SRC 3
`define ULBN_BIT_SEND_BRK 4
`define ULBN_IRQ_LBK 0
`define ULBN_IRQ_EDGE 1
`define ULBN_IRQ_IDLE 2
`define ULBN_IRQ_FULL 3
`define ULBN_IRQ_FERR 4
`define ULBN_IRQ_TXDONE 5
`define ULBN_RST_BYTE 8'h00
`define ULBN_BRK_TX_SHORT 5'd10
`define ULBN_BRK_TX_LONG 5'd13
`define ULBN_BRK_RX_SHORT 5'd10
`define ULBN_BRK_RX_LONG 5'd11
`define ULBN_IDLE_CHAR 5'd10
`define ULBN_OVS 5'd16
`endif

// File: src/ulbn_bitcnt.v
/*
  counts baud ticks of one line level, reports when a threshold is reached.
  assumes a one-cycle oversampling tick from the baud generator.
*/
`default_nettype none
module ulbn_bitcnt (
  input wire mclk,
  input wire rst_n,
  input wire tick,
  input wire run,
  input wire [4:0] limit,
  output reg hit
);
  reg [3:0] sub_q;
  reg [4:0] bits_q;
  always @(posedge mclk) begin
    if (!rst_n || !run) begin
      sub_q <= 4'h0;
      bits_q <= 5'h00;
      hit <= 1'b0;
    end else if (tick) begin
      sub_q <= sub_q + 4'h1;
      if (sub_q == 4'hf && bits_q != 5'h1f) begin
        bits_q <= bits_q + 5'h01;
      end
      // compare the count as it stands after this tick, so a run of exactly
      // limit bits is seen before the line leaves the level
      hit <= (((sub_q == 4'hf && bits_q != 5'h1f) ? bits_q + 5'h01 : bits_q) >= limit);
    end
  end
endmodule
`default_nettype wire

// File: tb/ulbn_top_sva.sv
/* bus and pin assertions of the serial block.
   assumes the top's ports and a baud tick every second clock. */
`default_nettype none
module ulbn_top_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic baud_tick,
  input wire logic transmit_pin_out,
  input wire logic transmit_pin_oe_n,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ticks of the current low run; 9 bits so a stuck pin shows before wrap
  logic [8:0] low_q;
  always_ff @(posedge mclk) begin
    low_q <= (!rst_n || transmit_pin_out) ? 9'h000 : low_q + {8'h00, baud_tick};
  end
  //////////////////////////////////////////////////////////////////////
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  req_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[1:2] !avs_waitrequest) else $error("request not answered");
  upper_zero_a: assert property (!avs_waitrequest && avs_read
    |-> avs_readdata[31:8] == 24'h000000) else $error("upper read bits set");
  unmapped_a: assert property (!avs_waitrequest && avs_read && avs_address[2:1] == 2'h3
    |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  rd_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  rst_out_a: assert property ($rose(rst_n) |-> avs_waitrequest && !irq
    && transmit_pin_out && !transmit_pin_oe_n) else $error("bad outputs after reset");
  brk_max_a: assert property (low_q <= 9'd225) else $error("low run too long");
  dir_write_a: assert property ($changed(transmit_pin_oe_n) |-> $past(avs_write)
    || $past(avs_write, 2) || $past(avs_write, 3)) else $error("pin turned on its own");
endmodule
bind ulbn_top ulbn_top_sva u_sva (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .baud_tick(baud_tick), .irq(irq),
  .transmit_pin_out(transmit_pin_out), .transmit_pin_oe_n(transmit_pin_oe_n));
`default_nettype wire

// File: tb/ulbn_node.sv
/* remote serial node: sends frames lsb first on the receive line.
   assumes 32 clocks a bit, i.e. a baud tick every second clock. */
`default_nettype none
module ulbn_node (
  input wire logic mclk,
  input wire logic inv,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl = 1'h1;
  // an inverting line driver: idle also flips, as a real one would
  assign line = lvl ^ inv;
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      lvl <= bits[i];
      repeat (32) @(posedge mclk);
    end
    lvl <= 1'h1;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
/* self-checking bench of the serial block: bus tasks, scenarios, verdict.
   assumes the remote node model and the defs header on the include path. */
`include "ulbn_defs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] AS = `ULBN_OFS_EXT_STATUS;
  localparam logic [2:0] AX = `ULBN_OFS_EXTRA_CTL;
  localparam logic [2:0] AC = `ULBN_OFS_CTL;
  localparam logic [2:0] AD = `ULBN_OFS_DATA;
  localparam logic [2:0] AI = `ULBN_OFS_IRQ_STATUS;
  localparam logic [2:0] AM = `ULBN_OFS_IRQ_MASK;
  logic mclk = 1'h0, rst_n = 1'h0, rd = 1'h0, wt = 1'h0, tick = 1'h0, inv = 1'h0;
  logic [2:0] adr = 3'h0;
  logic [31:0] wd = 32'h0, rdata, q;
  logic wreq, rxl, txo, txoe_n, txi, irq;
  int failures = 0, checked = 0;
  always #10 mclk = ~mclk;
  always @(posedge mclk) tick <= ~tick;
  assign txi = txoe_n ? 1'h1 : txo;  // pulled up when not driven
  ulbn_top u_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wt), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .baud_tick(tick), .receive_pin(rxl), .transmit_pin_in(txi), .transmit_pin_out(txo),
    .transmit_pin_oe_n(txoe_n), .irq(irq));
  ulbn_node u_node (.mclk(mclk), .inv(inv), .line(rxl));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    adr <= a;
    wd <= {24'h0, d};
    rd <= !w;
    wt <= w;
    do @(posedge mclk); while (wreq !== 1'h0);
    q = rdata;
    rd <= 1'h0;
    wt <= 1'h0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rg(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk(q & {24'h0, m}, {24'h0, e});
  endtask
  task automatic t_regs;
    for (int i = 0; i < 8; i++) rg(i[2:0], 8'hff, `ULBN_RST_BYTE);
    wr(3'h7, 8'hff);
    rg(3'h7, 8'hff, 8'h00);
  endtask
  task automatic t_edge;
    wr(AM, 8'h02);
    u_node.send(16'h03fe, 10);
    rg(AS, 8'h40, 8'h40);
    chk(irq, 1'h1);
    wr(AS, 8'h00);
    rg(AS, 8'h41, 8'h41);
    wr(AM, 8'h00);
    repeat (2) @(posedge mclk);
    chk(irq, 1'h0);
    wr(AM, 8'h02);
    wr(AS, 8'h40);
    wr(AI, 8'hff);
    repeat (2) @(posedge mclk);
    chk(irq, 1'h0);
    inv <= 1'h1;
    wr(AS, 8'h10);
    wr(AS, 8'hd0);
    wr(AI, 8'hff);
    u_node.send(16'h02b4, 10);
    rg(AD, 8'hff, 8'h5a);
    rg(AS, 8'h40, 8'h40);
    inv <= 1'h0;
    wr(AS, 8'hc0);
    wr(AI, 8'hff);
  endtask
  task automatic t_rx;
    wr(AC, 8'h01);
    fork u_node.send(16'h074a, 11); join_none
    repeat (48) @(posedge mclk);
    rg(AS, 8'h01, 8'h01);
    repeat (800) @(posedge mclk);
    rg(AX, 8'h80, 8'h80);
    rg(AI, 8'h1c, 8'h0c);
    rg(AD, 8'hff, 8'ha5);
    rg(AS, 8'h01, 8'h00);
    wr(AC, 8'h00);
    wr(AI, 8'hff);
  endtask
  task automatic t_lin;
    wr(AS, 8'h02);
    u_node.send(16'h0400, 11);  // ten low bits: short of the raised threshold
    rg(AS, 8'h80, 8'h00);
    u_node.send(16'h0800, 12);
    rg(AS, 8'h80, 8'h80);
    rg(AI, 8'h18, 8'h00);
    wr(AS, 8'h84);
    wr(AI, 8'hff);
    u_node.send(16'h0400, 11);
    rg(AI, 8'h18, 8'h18);
    rg(AS, 8'h80, 8'h00);
    wr(AS, 8'h00);
    wr(AI, 8'hff);
  endtask
  task automatic t_brk;
    int n;
    logic pt;
    for (int i = 0; i < 4; i++) begin
      wr(AS, {5'h00, i[1], 2'h0});
      // format first: the break length follows the stored format bit
      wr(AC, {7'h00, i[0]});
      wr(AC, {7'h08, i[0]});
      n = 0;
      pt = 1'h0;
      while (txo !== 1'h0) begin
        pt = tick;
        @(posedge mclk);
      end
      // count baud ticks, not clocks, so the tick phase cannot shift the result
      while (txo === 1'h0) begin
        n += pt;
        pt = tick;
        @(posedge mclk);
      end
      chk(n, 16 * (10 + i[0] + 3 * i[1]));
    end
    wr(AS, 8'h00);
  endtask
  task automatic t_nine;
    logic [8:0] v;
    wr(AX, 8'h40);
    for (int k = 0; k < 2; k++) begin
      wr(AD, k ? 8'haa : 8'h55);
      while (txo !== 1'h0) @(posedge mclk);
      repeat (16) @(posedge mclk);
      for (int b = 0; b < 9; b++) begin
        repeat (32) @(posedge mclk);
        v[b] = txo;
      end
      chk(v, k ? 9'h1aa : 9'h155);
      repeat (64) @(posedge mclk);
    end
    wr(AC, 8'h0c);
    repeat (2) @(posedge mclk);
    chk(txoe_n, 1'h1);
    wr(AX, 8'h20);
    repeat (2) @(posedge mclk);
    chk(txoe_n, 1'h0);
  endtask
  task automatic close_out;
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'h1;
    t_regs;
    t_edge;
    t_rx;
    t_lin;
    t_brk;
    t_nine;
    close_out;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    close_out;
  end
endmodule
`default_nettype wire
